/* rtl/camst_pkg.sv */
// Purpose: Shared constants for the camera status and exposure registers
// Assumes: 40 MHz pclk, APB byte addresses, MSB-first field numbering
// Notes:   Verilog bit index = 31 - documented bit number
package camst_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [31:0] ADDR_PRESENCE = 32'hF1000100;
    localparam logic [31:0] ADDR_FLAGS = 32'hF1000104;
    localparam logic [31:0] ADDR_MAX_SIZE = 32'hF1000200;
    localparam logic [31:0] ADDR_TICK = 32'hF1000208;
    localparam logic [31:0] ADDR_LONG = 32'hF100020C;
    localparam logic [31:0] ADDR_PATTERN = 32'hF1000210;
    localparam logic [31:0] ADDR_CTRL = 32'hF1000300;
    localparam logic [31:0] ADDR_SHUTTER = 32'hF1000304;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hF1000308;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hF100030C;

    // ****************************************
    // Field positions (Verilog indices)
    // ****************************************
    localparam int BIT_PRESENT = 31;
    localparam int BIT_ARMED = 16;
    localparam int BIT_ISO = 3;
    localparam int BIT_IDLE = 0;
    localparam int EXTRA_LSB = 12;
    localparam int PAT_INQ_MSB = 23;
    localparam int CTRL_TRIG_BIT = 0;
    localparam int IRQ_W = 3;
    localparam int IRQ_IDLE = 0;
    localparam int IRQ_LONG_DROP = 1;
    localparam int IRQ_STALL = 2;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [3:0] TICK_RST = 4'h4;
    localparam logic [3:0] TICK_MAX = 4'h8;
    localparam logic [11:0] SHUTTER_RST = 12'h001;
    localparam logic [11:0] SHUTTER_MIN = 12'h001;
    localparam logic [25:0] LONG_RST = 26'h0000014;
    localparam logic [3:0] PATTERN_RST = 4'h0;
    localparam logic [3:0] PATTERN_MAX = 4'h7;

    // ****************************************
    // Status poll spacing
    // ****************************************
    localparam int CLK_HZ = 40000000;
    localparam int STATUS_GAP_MS = 5;
    localparam int STATUS_GAP_CYC = CLK_HZ / 1000 * STATUS_GAP_MS;
    localparam int GAP_W = 18;

endpackage : camst_pkg

/* rtl/camst_tick_mult.sv */
// Purpose: Exposure tick lookup and shutter-times-tick product
// Assumes: Tick code already range checked by the caller
// Notes:   Purely combinational
module camst_tick_mult (
    // Operands
    input wire logic [3:0] tick_select,
    input wire logic [11:0] shutter,
    // Result
    output logic [9:0] tick_us,
    output logic [25:0] std_us
);
    import camst_pkg::*;

    always_comb begin
        case (tick_select) // R6
            4'h0: tick_us = 10'h001;
            4'h1: tick_us = 10'h002;
            4'h2: tick_us = 10'h005;
            4'h3: tick_us = 10'h00A;
            4'h4: tick_us = 10'h014;
            4'h5: tick_us = 10'h032;
            4'h6: tick_us = 10'h064;
            4'h7: tick_us = 10'h0C8;
            4'h8: tick_us = 10'h1F4;
            default: tick_us = 10'h014;
        endcase
    end

    // 12 x 10 bits fits in 22, padded to the 26-bit field
    assign std_us = {4'h0, 22'(shutter) * 22'(tick_us)};

endmodule : camst_tick_mult

/* rtl/camst_regs.sv */
// Purpose: APB register bank for camera status, tick, long exposure and patterns
// Assumes: Camera core signals are on pclk; APB3 slave with pslverr
// Notes:   Status-flag reads closer than the poll gap are stalled via pready
//
// Operation
// R1 - While idle, capture and transmit enables are held off.
// R2 - Trigger-armed flag is set whenever external triggering is configured.
// R3 - Status-flag reads closer than 5 ms apart get a delayed answer.
// R4 - Max-size register is read-only: rows high half, columns low half.
// R5 - Shutter is 12 bits, 1 to 4095; exposure is shutter times tick.
// R6 - Tick codes 0 to 8 mean 1,2,5,10,20,50,100,200,500 us.
// R7 - After reset the tick selects 20 us.
// R8 - Tick changes only while idle and apply at next shutter write.
// R9 - Exposure extra microseconds are reported and added to real exposure.
// R10 - Software treats a zero extra field as unknown.
// R11 - Long exposure is 26-bit microseconds, rounded to whole line times.
// R12 - Writing a long exposure below minimum stores the model minimum.
// R13 - Shutter writes mirror into long exposure; not the other way.
// R14 - Long-exposure writes take effect at once, even while transmitting.
// R15 - Format, mode or rate writes deactivate the long exposure.
// R16 - Seven pattern-available bits; select 0 disables, n activates pattern n.
// R17 - An active pattern turns off auto gain, shutter and white balance.
// R18 - Feature-present bits are read-only ones; writes ignored.
//
// Chosen here: the APB interface to the registers.
module camst_regs #(
    parameter int STATUS_GAP = camst_pkg::STATUS_GAP_CYC,
    parameter logic [15:0] SENSOR_ROWS = 16'h01E0,
    parameter logic [15:0] SENSOR_COLS = 16'h0280,
    parameter logic [11:0] EXPOSURE_EXTRA_US = 12'h020,
    parameter logic [25:0] MIN_EXPOSURE_US = 26'h000000A,
    parameter logic [25:0] LINE_US = 26'h0000001,
    parameter logic [6:0] PATTERN_AVAIL = 7'h7F,
    // Arbitrary implementation code
    parameter logic [7:0] IMPL_ID = 8'hA5
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Camera core status
    input wire logic camera_idle,
    input wire logic iso_active,
    input wire logic mode_reg_write,
    // Camera core control
    output logic ext_trigger_armed,
    output logic capture_en,
    output logic transmit_en,
    output logic [25:0] exposure_us,
    output logic [3:0] pattern_select,
    output logic auto_gain_off,
    output logic auto_shutter_off,
    output logic auto_wb_off,
    // Interrupt
    output logic irq
);
    import camst_pkg::*;

    // ****************************************
    // Bus decode
    // ****************************************
    logic access;
    logic flags_sel;
    logic gap_done;
    logic known;
    logic wr;
    logic rd_done;
    logic [31:0] rd_mux;
    logic [GAP_W-1:0] gap_cnt_reg;
    logic stall_seen_reg;
    logic [31:0] prdata_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_ev;
    logic trig_cfg_reg;
    logic idle_q_reg;
    logic [3:0] tick_reg;
    logic [11:0] shutter_reg;
    logic [11:0] shutter_next;
    logic [25:0] std_us_reg;
    logic [25:0] std_us_new;
    logic [25:0] long_reg;
    logic [25:0] long_next;
    logic [25:0] long_round;
    logic long_active_reg;
    logic [3:0] pattern_reg;
    logic [6:0] pat_inq;
    logic pat_ok;

    assign access = psel && penable;
    assign flags_sel = (paddr == ADDR_FLAGS) && !pwrite;
    assign gap_done = gap_cnt_reg >= GAP_W'(STATUS_GAP);
    // Stall only the status-flag read; everything else answers at once
    assign pready = !(access && flags_sel && !gap_done); // R3
    assign wr = access && pwrite && pready;
    assign rd_done = access && !pwrite && pready;
    assign known = (paddr == ADDR_PRESENCE) || (paddr == ADDR_FLAGS) || (paddr == ADDR_MAX_SIZE)
        || (paddr == ADDR_TICK) || (paddr == ADDR_LONG) || (paddr == ADDR_PATTERN)
        || (paddr == ADDR_CTRL) || (paddr == ADDR_SHUTTER) || (paddr == ADDR_IRQ_STATUS)
        || (paddr == ADDR_IRQ_MASK);
    assign pslverr = access && pready && !known;
    assign prdata = prdata_reg;

    // ****************************************
    // Poll spacing
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_reg <= GAP_W'(STATUS_GAP);
        end else if (rd_done && flags_sel) begin
            gap_cnt_reg <= '0; // R3
        end else if (!gap_done) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_seen_reg <= 1'b0;
        end else if (rd_done) begin
            stall_seen_reg <= 1'b0;
        end else if (!pready) begin
            stall_seen_reg <= 1'b1;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_inq
            // Pattern n sits at documented bit 7+n
            assign pat_inq[6-gi] = PATTERN_AVAIL[gi]; // R16
        end
    endgenerate

    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            ADDR_PRESENCE: begin
                rd_mux[BIT_PRESENT] = 1'b1; // R18
                rd_mux[7:0] = IMPL_ID;
            end
            ADDR_FLAGS: begin
                rd_mux[BIT_ARMED] = ext_trigger_armed; // R2
                rd_mux[BIT_ISO] = iso_active;
                rd_mux[BIT_IDLE] = camera_idle;
            end
            ADDR_MAX_SIZE: rd_mux = {SENSOR_ROWS, SENSOR_COLS}; // R4
            ADDR_TICK: begin
                rd_mux[BIT_PRESENT] = 1'b1; // R18
                rd_mux[EXTRA_LSB +: 12] = EXPOSURE_EXTRA_US; // R9
                rd_mux[3:0] = tick_reg;
            end
            ADDR_LONG: begin
                rd_mux[BIT_PRESENT] = 1'b1; // R18
                rd_mux[25:0] = long_reg;
            end
            ADDR_PATTERN: begin
                rd_mux[BIT_PRESENT] = 1'b1; // R18
                rd_mux[PAT_INQ_MSB -: 7] = pat_inq; // R16
                rd_mux[3:0] = pattern_reg;
            end
            ADDR_CTRL: rd_mux[CTRL_TRIG_BIT] = trig_cfg_reg;
            ADDR_SHUTTER: rd_mux[11:0] = shutter_reg;
            ADDR_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_reg;
            ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Captured in setup and refreshed while stalled, so flags are fresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (psel && !pwrite && (!penable || !pready)) begin
            prdata_reg <= rd_mux;
        end
    end

    // ****************************************
    // Control and trigger
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_cfg_reg <= 1'b0;
        end else if (wr && paddr == ADDR_CTRL) begin
            trig_cfg_reg <= pwdata[CTRL_TRIG_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_trigger_armed <= 1'b0;
            capture_en <= 1'b0;
            transmit_en <= 1'b0;
            // Core comes out of reset idle; avoids a false idle event
            idle_q_reg <= 1'b1;
        end else begin
            ext_trigger_armed <= trig_cfg_reg; // R2
            capture_en <= !camera_idle; // R1
            transmit_en <= !camera_idle; // R1
            idle_q_reg <= camera_idle;
        end
    end

    // ****************************************
    // Tick select and shutter
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= TICK_RST; // R7
        end else if (wr && paddr == ADDR_TICK && camera_idle && pwdata[3:0] <= TICK_MAX) begin // R6
            tick_reg <= pwdata[3:0]; // R8
        end
    end

    assign shutter_next = (pwdata[11:0] < SHUTTER_MIN) ? SHUTTER_MIN : pwdata[11:0]; // R5

    camst_tick_mult u_tick_mult (
        .tick_select(tick_reg),
        .shutter(shutter_next),
        .tick_us(),
        .std_us(std_us_new)
    );

    // Tick takes effect here, not when written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutter_reg <= SHUTTER_RST;
            std_us_reg <= LONG_RST;
        end else if (wr && paddr == ADDR_SHUTTER) begin
            shutter_reg <= shutter_next; // R5
            std_us_reg <= std_us_new; // R8
        end
    end

    // ****************************************
    // Long exposure
    // ****************************************
    assign long_next = (pwdata[25:0] < MIN_EXPOSURE_US) ? MIN_EXPOSURE_US : pwdata[25:0]; // R12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_reg <= LONG_RST;
        end else if (wr && paddr == ADDR_SHUTTER) begin
            long_reg <= std_us_new; // R13
        end else if (wr && paddr == ADDR_LONG) begin
            long_reg <= long_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_active_reg <= 1'b0;
        end else if (mode_reg_write) begin
            long_active_reg <= 1'b0; // R15
        end else if (wr && paddr == ADDR_LONG) begin
            long_active_reg <= 1'b1; // R14
        end else if (wr && paddr == ADDR_SHUTTER) begin
            long_active_reg <= 1'b0;
        end
    end

    // Nearest whole line time; LINE_US of one means no rounding
    assign long_round = 26'(((long_reg + (LINE_US >> 1)) / LINE_US) * LINE_US); // R11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exposure_us <= LONG_RST;
        end else if (long_active_reg) begin
            exposure_us <= 26'(long_round + 26'(EXPOSURE_EXTRA_US)); // R14
        end else begin
            exposure_us <= 26'(std_us_reg + 26'(EXPOSURE_EXTRA_US)); // R9
        end
    end

    // ****************************************
    // Test patterns
    // ****************************************
    // Unavailable pattern numbers are ignored rather than half-applied
    assign pat_ok = (pwdata[3:0] == 4'h0)
        || (pwdata[3:0] <= PATTERN_MAX && PATTERN_AVAIL[3'(pwdata[3:0] - 4'h1)]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_reg <= PATTERN_RST;
        end else if (wr && paddr == ADDR_PATTERN && pat_ok) begin
            pattern_reg <= pwdata[3:0]; // R16
        end
    end

    assign pattern_select = pattern_reg;
    assign auto_gain_off = pattern_reg != 4'h0; // R17
    assign auto_shutter_off = pattern_reg != 4'h0; // R17
    assign auto_wb_off = pattern_reg != 4'h0; // R17

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_ev[IRQ_IDLE] = camera_idle && !idle_q_reg;
    assign irq_ev[IRQ_LONG_DROP] = mode_reg_write && long_active_reg;
    assign irq_ev[IRQ_STALL] = rd_done && flags_sel && stall_seen_reg;

    // Only bits that were read get cleared; a new event always wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
        end else if (rd_done && paddr == ADDR_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~prdata_reg[IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_status_reg <= irq_status_reg | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= '0;
        end else if (wr && paddr == ADDR_IRQ_MASK) begin
            irq_mask_reg <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ****************************************
    // Checks
    // ****************************************
    sequence s_flags_early;
        access && flags_sel && (gap_cnt_reg < GAP_W'(STATUS_GAP));
    endsequence

    sequence s_long_write;
        wr && paddr == ADDR_LONG && !mode_reg_write;
    endsequence

    a_idle_blocks_capture: assert property (@(posedge pclk) disable iff (!presetn) // R1
        camera_idle |=> !capture_en && !transmit_en)
        else $error("capture or transmit enabled while idle");

    a_armed_follows_cfg: assert property (@(posedge pclk) disable iff (!presetn) // R2
        wr && paddr == ADDR_CTRL && pwdata[CTRL_TRIG_BIT] |=> ##1 ext_trigger_armed)
        else $error("trigger armed flag not set after configuration");

    a_poll_gap_stall: assert property (@(posedge pclk) disable iff (!presetn) // R3
        rd_done && flags_sel ##2 (access && flags_sel) |-> !pready)
        else $error("status read answered inside poll gap");

    a_early_read_held: assert property (@(posedge pclk) disable iff (!presetn) // R3
        s_flags_early |-> !pready)
        else $error("early status read not delayed");

    a_size_readback: assert property (@(posedge pclk) disable iff (!presetn) // R4
        rd_done && paddr == ADDR_MAX_SIZE |-> prdata == {SENSOR_ROWS, SENSOR_COLS})
        else $error("max size readback wrong");

    a_tick_reset_value: assert property (@(posedge pclk) // R7
        !presetn |=> tick_reg == TICK_RST)
        else $error("tick select not 20 us after reset");

    a_tick_busy_ignored: assert property (@(posedge pclk) disable iff (!presetn) // R8
        wr && paddr == ADDR_TICK && !camera_idle |=> $stable(tick_reg))
        else $error("tick changed while not idle");

    a_long_min_clamp: assert property (@(posedge pclk) disable iff (!presetn) // R12
        s_long_write ##0 (pwdata[25:0] < MIN_EXPOSURE_US) |=> long_reg == MIN_EXPOSURE_US)
        else $error("long exposure not clamped to minimum");

    a_shutter_mirror: assert property (@(posedge pclk) disable iff (!presetn) // R13
        wr && paddr == ADDR_SHUTTER |=> long_reg == std_us_reg && !long_active_reg)
        else $error("shutter write not mirrored");

    a_long_immediate: assert property (@(posedge pclk) disable iff (!presetn) // R14
        s_long_write ##1 !mode_reg_write |=> exposure_us == 26'(long_round + 26'(EXPOSURE_EXTRA_US)))
        else $error("long exposure not applied at once");

    a_mode_drops_long: assert property (@(posedge pclk) disable iff (!presetn) // R15
        mode_reg_write |=> !long_active_reg ##1 exposure_us == 26'($past(std_us_reg) + 26'(EXPOSURE_EXTRA_US)))
        else $error("long exposure survived mode write");

    a_pattern_auto_off: assert property (@(posedge pclk) disable iff (!presetn) // R17
        wr && paddr == ADDR_PATTERN && pat_ok && pwdata[3:0] != 4'h0 |=> auto_gain_off && auto_wb_off)
        else $error("auto features still on with pattern");

    a_presence_fixed: assert property (@(posedge pclk) disable iff (!presetn) // R18
        rd_done && (paddr == ADDR_TICK || paddr == ADDR_LONG || paddr == ADDR_PATTERN) |-> prdata[BIT_PRESENT])
        else $error("presence bit not one");

endmodule : camst_regs

/* verification/camst_core_model.sv */
// Purpose: Behavioural camera core facing the register bank
// Assumes: Same pclk domain as the bank
// Notes:   Bench steers run and mode_pulse; model answers one edge later
module camst_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input wire logic run,
    input wire logic mode_pulse,
    // Core status
    output logic camera_idle,
    output logic iso_active,
    output logic mode_reg_write
);
    // ****************************************
    // Status flags
    // ****************************************
    // Registered so the bank never sees a same-edge change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            camera_idle <= 1'b1;
            iso_active <= 1'b0;
            mode_reg_write <= 1'b0;
        end else begin
            camera_idle <= !run;
            iso_active <= run;
            mode_reg_write <= mode_pulse;
        end
    end
endmodule : camst_core_model

/* verification/testbench.sv */
// Purpose: Self-checking bench for the camera status and exposure bank
// Assumes: Poll gap shortened to 20 cycles, default model parameters
// Notes:   APB master changes signals only just after a rising edge
module testbench import camst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 20;
    localparam logic [25:0] EXTRA = 26'h20;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, mode_pulse = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic pready, pslverr, camera_idle, iso_active, mode_reg_write, irq, err;
    logic ext_trigger_armed, capture_en, transmit_en, auto_gain_off, auto_shutter_off, auto_wb_off;
    logic [25:0] exposure_us;
    logic [3:0] pattern_select;
    int error_cnt = 0, num_checks = 0, waits;
    int tick_tab[9] = '{1, 2, 5, 10, 20, 50, 100, 200, 500};
    always #12.5 pclk = ~pclk;
    camst_regs #(.STATUS_GAP(GAP)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .camera_idle, .iso_active, .mode_reg_write, .ext_trigger_armed, .capture_en,
        .transmit_en, .exposure_us, .pattern_select, .auto_gain_off, .auto_shutter_off, .auto_wb_off, .irq);
    camst_core_model core (.pclk, .presetn, .run, .mode_pulse, .camera_idle, .iso_active, .mode_reg_write);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Ends one edge after release so a following call never double-drives
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        waits = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            waits++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        apb(1, ADDR_PRESENCE, 32'h0);
        apb(0, ADDR_PRESENCE, 0);
        check("presence", rd, 32'h800000A5);
        apb(1, ADDR_MAX_SIZE, 32'h0);
        apb(0, ADDR_MAX_SIZE, 0);
        check("max size", rd, 32'h01E00280);
        apb(0, ADDR_TICK, 0);
        check("tick reset", rd, {1'b1, 7'h0, 12'h020, 8'h0, TICK_RST});
        check("extra known", rd[23:12] != 12'h0, 1'b1);
        check("reset exposure", exposure_us, 26'd20 + EXTRA);
        apb(0, ADDR_PATTERN, 0);
        check("pattern reset", rd, 32'h80FE0000);
        check("capture idle", {capture_en, transmit_en}, 2'b00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_tick();
        for (int c = 0; c < 9; c++) begin
            apb(1, ADDR_TICK, c);
            apb(1, ADDR_SHUTTER, 32'h3);
            apb(0, ADDR_LONG, 0);
            check("mirror", rd, {6'h20, 26'(3 * tick_tab[c])});
            check("exposure", exposure_us, 26'(3 * tick_tab[c]) + EXTRA);
        end
        apb(1, ADDR_TICK, 32'h9);
        apb(0, ADDR_TICK, 0);
        check("code nine", rd[3:0], 4'h8);
        apb(1, ADDR_TICK, 32'h0);
        cyc(3);
        check("pending tick", exposure_us, 26'd1500 + EXTRA);
        run <= 1'b1;
        cyc(3);
        check("busy out", {capture_en, transmit_en}, 2'b11);
        apb(0, ADDR_FLAGS, 0);
        check("busy flags", rd, 32'h00000008);
        apb(1, ADDR_TICK, 32'h5);
        apb(0, ADDR_TICK, 0);
        check("busy tick", rd[3:0], 4'h0);
        $display("test tick done");
    endtask : t_tick
    task automatic t_long();
        apb(1, ADDR_LONG, 32'h1);
        apb(0, ADDR_LONG, 0);
        check("long min", rd, 32'h8000000A);
        apb(1, ADDR_LONG, 32'd1000);
        cyc(2);
        check("long now", exposure_us, 26'd1000 + EXTRA);
        apb(0, ADDR_SHUTTER, 0);
        check("shutter kept", rd[11:0], 12'h3);
        mode_pulse <= 1'b1;
        @(posedge pclk);
        mode_pulse <= 1'b0;
        cyc(4);
        check("long dropped", exposure_us, 26'd1500 + EXTRA);
        apb(0, ADDR_IRQ_STATUS, 0);
        check("drop event", rd[IRQ_LONG_DROP], 1'b1);
        run <= 1'b0;
        cyc(3);
        $display("test long done");
    endtask : t_long
    task automatic t_pattern();
        for (int p = 0; p < 9; p++) begin
            apb(1, ADDR_PATTERN, p);
            cyc(1);
            check("select", pattern_select, (p > 7) ? 4'h7 : 4'(p));
            check("autos", {auto_gain_off, auto_shutter_off, auto_wb_off}, {3{p != 0}});
        end
        $display("test pattern done");
    endtask : t_pattern
    task automatic t_status();
        apb(1, ADDR_CTRL, 32'h1);
        apb(1, ADDR_IRQ_MASK, 32'h4);
        apb(0, ADDR_IRQ_STATUS, 0);
        check("idle event", rd[IRQ_IDLE], 1'b1);
        cyc(GAP);
        apb(0, ADDR_FLAGS, 0);
        check("flags", rd, 32'h00010001);
        check("free read", waits, 0);
        check("armed pin", ext_trigger_armed, 1'b1);
        apb(0, ADDR_FLAGS, 0);
        check("stalled", waits > 10 && waits <= GAP, 1'b1);
        cyc(1);
        check("irq set", irq, 1'b1);
        apb(0, ADDR_IRQ_STATUS, 0);
        check("irq bit", rd[IRQ_STALL], 1'b1);
        cyc(1);
        check("irq cleared", irq, 1'b0);
        apb(0, 32'hF1000400, 0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        $display("test status done");
    endtask : t_status
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        cyc(5);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tick();
        t_long();
        t_pattern();
        t_status();
        finish_test();
    end
    initial begin
        #(25 * 20000);
        error_cnt++;
        finish_test();
    end
endmodule : testbench
